// >>> src/reset_seq_regs.svh
`ifndef RESET_SEQ_REGS_SVH
`define RESET_SEQ_REGS_SVH
// bus register byte offsets
`define CTRL_OFFSET            12'h000
`define STATUS_OFFSET          12'h004
`define STRAPS_OFFSET          12'h008
`define OVERRIDE_OFFSET        12'h00c
// ctrl field positions
`define CTRL_SOFT_RESET_BIT    0
`define CTRL_PHY_RESET_BIT     1
`define CTRL_MAC_RESET_BIT     2
`define CTRL_RESET_VALUE       32'h0000_0000
// straps field positions
`define STRAP_ROLE_BIT         0
`define STRAP_TX_LEVEL_BIT     1
`define STRAP_POWERDOWN_BIT    2
`define STRAP_SPI_CRC_BIT      3
// override field positions
`define OVR_AUTONEG_BIT        0
`define OVERRIDE_RESET_VALUE   32'h0000_0001
// status field positions
`define STATUS_STATE_LSB       0
`define STATUS_RUNNING_BIT     4
`define STATUS_MASTER_BIT      5
`define STATUS_TX_HI_BIT       6
`define STATUS_SW_PD_BIT       7
// timing, in their own units, then cycles at 125 MHz
`define CLOCK_MHZ              125
`define PIN_MIN_LOW_US         10
`define DEGLITCH_US            1
`define DEGLITCH_CYCLES        (`DEGLITCH_US * `CLOCK_MHZ + 1)
`define TRISTATE_CYCLES        16
`define STRAP_SAMPLE_CYCLES    4
`define RELEASE_MAX_MS         50
`define RELEASE_MAX_CYCLES     (`RELEASE_MAX_MS * 1000 * `CLOCK_MHZ)
`define XTAL_SETTLE_US         20000
`define XTAL_SETTLE_CYCLES     (`XTAL_SETTLE_US * `CLOCK_MHZ)
`define PLL_LOCK_US            10000
`define PLL_LOCK_CYCLES        (`PLL_LOCK_US * `CLOCK_MHZ)
`define SUB_RESET_NS           1200
`define SUB_RESET_CYCLES       ((`SUB_RESET_NS + 7) / 8)
`endif

// >>> src/reset_seq_pkg.sv
package reset_seq_pkg;
  typedef enum logic [2:0] {
    st_hold,
    st_tristate,
    st_sample,
    st_xtal,
    st_pll,
    st_run
  } seq_state_type;
endpackage

// >>> src/strap_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// carries the latched strap values between the latch and the top
interface strap_bus_if;
  logic role_preference;
  logic tx_level;
  logic powerdown_after_reset;
  logic spi_crc;
  logic capture;
  modport latch (input capture, output role_preference, tx_level,
                 output powerdown_after_reset, spi_crc);
  modport user  (output capture, input role_preference, tx_level,
                 input powerdown_after_reset, spi_crc);
endinterface
`default_nettype wire

// >>> src/reset_deglitch.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_regs.svh"
module reset_deglitch (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin_reset_n,
  output logic      reset_taken
);
  logic [8:0] low_count;
  // ------------------------------------------------------------
  // low-pulse filter
  // ------------------------------------------------------------
  // reject short pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_count <= 9'h000;
    end else if (pin_reset_n) begin
      low_count <= 9'h000;
    end else if (low_count != 9'(`DEGLITCH_CYCLES)) begin
      low_count <= low_count + 9'h001;
    end
  end
  // asserted only once the pin has stayed low longer than the glitch window
  assign reset_taken = (low_count == 9'(`DEGLITCH_CYCLES));
endmodule // reset_deglitch
`default_nettype wire

// >>> src/strap_latch.sv
`timescale 1ns/1ps
`default_nettype none
module strap_latch (
  input  wire logic    hclk,
  input  wire logic    hresetn,
  input  wire logic    role_preference_strap,
  input  wire logic    tx_level_strap,
  input  wire logic    powerdown_after_reset_strap,
  input  wire logic    spi_crc_strap,
  strap_bus_if.latch   straps
);
  logic [3:0] held;
  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  // hold until next reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held <= 4'h0;
    end else if (straps.capture) begin
      held <= {spi_crc_strap, powerdown_after_reset_strap,
               tx_level_strap, role_preference_strap};
    end
  end
  assign straps.role_preference       = held[0];
  assign straps.tx_level              = held[1];
  assign straps.powerdown_after_reset = held[2];
  assign straps.spi_crc               = held[3];
endmodule // strap_latch
`default_nettype wire

// >>> src/reset_and_strap_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_regs.svh"
module reset_and_strap_sequencer #(
  parameter int unsigned XTAL_CYCLES = `XTAL_SETTLE_CYCLES,
  parameter int unsigned PLL_CYCLES  = `PLL_LOCK_CYCLES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // supplies and reset pin
  input  wire logic        supplies_good,
  input  wire logic        pin_reset_n,
  // strap pins, pulled down on the pad
  input  wire logic        role_preference_strap,
  input  wire logic        tx_level_strap,
  input  wire logic        powerdown_after_reset_strap,
  input  wire logic        spi_crc_strap,
  // sequencing outputs
  output logic             io_tristate,
  output logic             xtal_enable,
  output logic             pll_enable,
  output logic             core_reset_n,
  output logic             phy_reset_n,
  output logic             mac_reset_n,
  output logic             spi_out_force_low,
  output logic             regs_accessible,
  // strap-derived defaults
  output logic             prefer_master,
  output logic             tx_high_level_enable,
  output logic             software_powerdown,
  output logic             spi_crc_enable
);
  reset_seq_pkg::seq_state_type state;
  reset_seq_pkg::seq_state_type next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic        reset_taken;
  logic        autoneg_enable;
  logic [7:0]  phy_count;
  logic [7:0]  mac_count;
  logic        soft_req;
  logic        wr_pend;
  logic [11:0] addr_q;
  strap_bus_if straps ();

  // ------------------------------------------------------------
  // reset pin filter and strap latch
  // ------------------------------------------------------------
  // the pin counts as a reset only once the filter window has passed; the
  // filter never stretches a pulse, so a host must hold the pin low itself
  reset_deglitch u_deglitch (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pin_reset_n (pin_reset_n),
    .reset_taken (reset_taken)
  );
  // pads pull low, so zero defaults
  strap_latch u_straps (
    .hclk                        (hclk),
    .hresetn                     (hresetn),
    .role_preference_strap       (role_preference_strap),
    .tx_level_strap              (tx_level_strap),
    .powerdown_after_reset_strap (powerdown_after_reset_strap),
    .spi_crc_strap               (spi_crc_strap),
    .straps                      (straps)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // any reset cause restarts
  wire hold_cause = !supplies_good || reset_taken || soft_req;
  wire timer_done = (timer == 32'h0000_0000);
  assign straps.capture = (state == reset_seq_pkg::st_sample);

  // the timer loads on entry to each timed state and counts down to zero; any hold
  // cause wins over the count, so a cause arriving mid-sequence restarts it
  always_comb begin
    next_state = state;
    next_timer = timer - 32'h0000_0001;
    if (timer_done) begin
      next_timer = timer;
    end
    case (state)
      reset_seq_pkg::st_hold: begin
        if (!hold_cause) begin
          next_state = reset_seq_pkg::st_tristate;
          next_timer = 32'(`TRISTATE_CYCLES);
        end
      end
      reset_seq_pkg::st_tristate: begin
        if (timer_done) begin
          next_state = reset_seq_pkg::st_sample;
          next_timer = 32'(`STRAP_SAMPLE_CYCLES);
        end
      end
      reset_seq_pkg::st_sample: begin
        if (timer_done) begin
          next_state = reset_seq_pkg::st_xtal;
          next_timer = XTAL_CYCLES;
        end
      end
      reset_seq_pkg::st_xtal: begin
        if (timer_done) begin
          next_state = reset_seq_pkg::st_pll;
          next_timer = PLL_CYCLES;
        end
      end
      reset_seq_pkg::st_pll: begin
        if (timer_done) begin
          next_state = reset_seq_pkg::st_run;
        end
      end
      reset_seq_pkg::st_run: begin
      end
      default: begin
        next_state = reset_seq_pkg::st_hold;
      end
    endcase
    if (hold_cause) begin
      next_state = reset_seq_pkg::st_hold;
      next_timer = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= reset_seq_pkg::st_hold;
      timer <= 32'h0000_0000;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // ------------------------------------------------------------
  // subsystem resets, about 1.2 us each
  // ------------------------------------------------------------
  wire running   = (state == reset_seq_pkg::st_run);
  wire wr_ctrl   = wr_pend && (addr_q == `CTRL_OFFSET);
  wire phy_start = wr_ctrl && hwdata[`CTRL_PHY_RESET_BIT];
  wire mac_start = wr_ctrl && hwdata[`CTRL_MAC_RESET_BIT];
  wire soft_set  = wr_ctrl && hwdata[`CTRL_SOFT_RESET_BIT];

  // a subsystem reset leaves the sequencer and the straps alone; of the ctrl bits only the
  // full soft reset reruns the sequence and relatches the straps
  // phy and mac short resets
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_count <= 8'h00;
      mac_count <= 8'h00;
      soft_req  <= 1'b0;
    end else begin
      phy_count <= phy_start ? 8'(`SUB_RESET_CYCLES)
                 : (phy_count != 8'h00) ? phy_count - 8'h01 : 8'h00;
      mac_count <= mac_start ? 8'(`SUB_RESET_CYCLES)
                 : (mac_count != 8'h00) ? mac_count - 8'h01 : 8'h00;
      // one-cycle request that drops the sequencer back to hold
      soft_req  <= soft_set;
    end
  end

  // ------------------------------------------------------------
  // outputs, all registered
  // ------------------------------------------------------------
  // io released only after sampling
  wire next_tristate = (state == reset_seq_pkg::st_hold) ||
                       (state == reset_seq_pkg::st_tristate) ||
                       (state == reset_seq_pkg::st_sample);
  wire next_xtal     = (state == reset_seq_pkg::st_xtal) ||
                       (state == reset_seq_pkg::st_pll) || running;
  wire next_pll      = (state == reset_seq_pkg::st_pll) || running;
  wire next_mac_rst  = !running || (mac_count != 8'h00);
  // role from strap, whatever the autoneg setting
  wire next_master   = straps.role_preference;
  wire next_tx_hi    = !straps.tx_level;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_tristate          <= 1'b1;
      xtal_enable          <= 1'b0;
      pll_enable           <= 1'b0;
      core_reset_n         <= 1'b0;
      phy_reset_n          <= 1'b0;
      mac_reset_n          <= 1'b0;
      spi_out_force_low    <= 1'b1;
      regs_accessible      <= 1'b0;
      prefer_master        <= 1'b0;
      tx_high_level_enable <= 1'b1;
      software_powerdown   <= 1'b1;
      spi_crc_enable       <= 1'b0;
    end else begin
      io_tristate          <= next_tristate;
      xtal_enable          <= next_xtal;
      pll_enable           <= next_pll;
      core_reset_n         <= running;
      phy_reset_n          <= running && (phy_count == 8'h00);
      mac_reset_n          <= !next_mac_rst;
      // spi outputs low in mac reset
      spi_out_force_low    <= next_mac_rst;
      regs_accessible      <= running;
      prefer_master        <= next_master;
      tx_high_level_enable <= next_tx_hi;
      software_powerdown   <= !straps.powerdown_after_reset;
      spi_crc_enable       <= straps.spi_crc;
    end
  end

  // ------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ------------------------------------------------------------
  wire take = hsel && hready && htrans[1];
  // the address is captured on every edge, but only a taken write raises
  // the write flag, so idle cycles never disturb a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      addr_q  <= 12'h000;
    end else begin
      wr_pend <= take && hwrite;
      addr_q  <= haddr;
    end
  end

  // override register, autoneg enable by default
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      autoneg_enable <= 1'b1;
    end else if (wr_pend && addr_q == `OVERRIDE_OFFSET) begin
      autoneg_enable <= hwdata[`OVR_AUTONEG_BIT];
    end
  end

  // status packs the state code, the run flag and the strap defaults except spi crc
  wire [31:0] status_word = {24'h00_0000, software_powerdown, tx_high_level_enable,
                             prefer_master, running, 1'b0, state};
  wire [31:0] strap_word  = {28'h000_0000, straps.spi_crc, straps.powerdown_after_reset,
                             straps.tx_level, straps.role_preference};
  // decoding the live address phase gives read data with no wait state;
  // the cost is a longer path from haddr into hrdata
  // read decode, unmapped reads as zero
  wire [31:0] read_word = (haddr == `STATUS_OFFSET)   ? status_word
                        : (haddr == `STRAPS_OFFSET)   ? strap_word
                        : (haddr == `OVERRIDE_OFFSET) ? {31'h0000_0000, autoneg_enable}
                        : 32'h0000_0000;

  // read data registered in the address phase edge, held in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= read_word;
    end
  end

  // bus answer flops: this slave never stretches a transfer nor returns an
  // error, but its answer still leaves from flops like every other output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule // reset_and_strap_sequencer
`default_nettype wire

// >>> verification/board_reset_source.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------
// board side: reset pin driver and supply monitor stand-in
// -----------------------------------------------------------------
module board_reset_source (
  input  wire logic hclk,
  output logic      pin_reset_n,
  output logic      supplies_good
);
  // idle board: pin released, supplies good
  initial begin
    pin_reset_n   = 1'b1;
    supplies_good = 1'b1;
  end

  // drive the pin low for n cycles; callers choose glitch or real reset
  // long enough low
  task automatic pin_low(input int n);
    @(posedge hclk);
    pin_reset_n <= 1'b0;
    repeat (n) @(posedge hclk);
    pin_reset_n <= 1'b1;
  endtask

  // brown-out: supplies drop for n cycles, then recover
  task automatic supply_dip(input int n);
    @(posedge hclk);
    supplies_good <= 1'b0;
    repeat (n) @(posedge hclk);
    supplies_good <= 1'b1;
  endtask
endmodule // board_reset_source
`default_nettype wire

// >>> verification/reset_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------
// port checker for the reset and strap sequencer
// -----------------------------------------------------------------
module reset_seq_asserts (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic supplies_good,
  input  wire logic pin_reset_n,
  input  wire logic io_tristate,
  input  wire logic xtal_enable,
  input  wire logic pll_enable,
  input  wire logic core_reset_n,
  input  wire logic mac_reset_n,
  input  wire logic spi_out_force_low,
  input  wire logic prefer_master,
  input  wire logic tx_high_level_enable,
  input  wire logic software_powerdown,
  input  wire logic spi_crc_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [7:0] low_cnt;

  // consecutive low cycles on the pin, saturating so it never wraps
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_cnt <= 8'h00;
    else if (pin_reset_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
  end

  glitch_ignored_a: assert property ((low_cnt inside {[1:125]}) && supplies_good &&
    $past(supplies_good) && $past(core_reset_n) |-> core_reset_n)
    else $error("short pin pulse reset the core");
  long_low_a: assert property (low_cnt == 8'd130 |-> !core_reset_n)
    else $error("long pin low did not reset the core");
  supply_drop_a: assert property (!supplies_good |-> ##[1:2] !core_reset_n)
    else $error("supply drop did not hold reset");
  release_order_a: assert property ($rose(core_reset_n) |->
    supplies_good && pll_enable && !io_tristate)
    else $error("core released before supplies, clocks and pins were ready");
  xtal_before_pll_a: assert property ($rose(pll_enable) |-> $past(xtal_enable, 8))
    else $error("pll enabled without crystal settle time");
  pll_needs_xtal_a: assert property (pll_enable |-> xtal_enable)
    else $error("pll enabled while crystal off");
  spi_low_a: assert property (!mac_reset_n |-> spi_out_force_low)
    else $error("spi outputs not forced low during mac reset");
  strap_hold_a: assert property (core_reset_n && $past(core_reset_n) |->
    $stable({prefer_master, tx_high_level_enable, software_powerdown, spi_crc_enable}))
    else $error("strap defaults changed while running");
  run_io_a: assert property (core_reset_n |-> !io_tristate)
    else $error("pins still tristated while running");

  cover property ($rose(core_reset_n));
  cover property (low_cnt == 8'd120 ##1 pin_reset_n);
  cover property (!mac_reset_n && core_reset_n);
endmodule // reset_seq_asserts

bind reset_and_strap_sequencer reset_seq_asserts reset_seq_asserts_i (
  .hclk, .hresetn, .supplies_good, .pin_reset_n, .io_tristate, .xtal_enable,
  .pll_enable, .core_reset_n, .mac_reset_n, .spi_out_force_low, .prefer_master,
  .tx_high_level_enable, .software_powerdown, .spi_crc_enable
);
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_regs.svh"
module tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_phase, probe;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        pin_reset_n, supplies_good, io_tristate, xtal_enable, pll_enable;
  logic        core_reset_n, phy_reset_n, mac_reset_n, spi_out_force_low, regs_accessible;
  logic        prefer_master, tx_high_level_enable, software_powerdown, spi_crc_enable;
  logic [3:0]  straps;
  logic [10:0] outs, run_exp;
  logic [63:0] exp_q[$];
  int          fails, n_compared, cycles;

  reset_and_strap_sequencer #(.XTAL_CYCLES(20), .PLL_CYCLES(10)) reset_and_strap_sequencer_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .supplies_good, .pin_reset_n,
    .role_preference_strap(straps[0]), .tx_level_strap(straps[1]),
    .powerdown_after_reset_strap(straps[2]), .spi_crc_strap(straps[3]),
    .io_tristate, .xtal_enable, .pll_enable, .core_reset_n, .phy_reset_n, .mac_reset_n,
    .spi_out_force_low, .regs_accessible, .prefer_master, .tx_high_level_enable,
    .software_powerdown, .spi_crc_enable);

  board_reset_source board_reset_source_i (.hclk, .pin_reset_n, .supplies_good);

  assign outs = {hresp, regs_accessible, phy_reset_n, mac_reset_n,
                 prefer_master, tx_high_level_enable, software_powerdown, spi_crc_enable,
                 core_reset_n, io_tristate, spi_out_force_low};

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one word transfer; the read expectation is queued with a full mask
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= wr; hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d; rd_phase <= !wr;
    if (!wr) exp_q.push_back({32'hffff_ffff, d});
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
  endtask

  // note expected output levels under a mask; the monitor samples next edge
  task automatic expect_outs(input logic [10:0] e, input logic [10:0] m);
    @(posedge hclk);
    probe <= 1'b1;
    exp_q.push_back({21'h0, m, 21'h0, e});
    @(posedge hclk);
    probe <= 1'b0;
  endtask

  task automatic wait_run();
    for (int i = 0; i < 500 && core_reset_n !== 1'b1; i++) @(posedge hclk);
    run_exp = {4'b0111, straps[0], ~straps[1], ~straps[2], straps[3], 3'b100};
  endtask

  // monitor: oldest note against whatever result shows at this edge
  always @(posedge hclk) begin
    logic [63:0] n;
    if ((rd_phase && hreadyout) || probe) begin
      n = exp_q.pop_front();
      check((rd_phase ? hrdata : {21'h0, outs}) & n[63:32], n[31:0]);
    end
  end

  // cycle ceiling well above the roughly 1900 cycles the tests need
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; htrans = 2'b00; haddr = 12'h000; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; rd_phase = 1'b0; probe = 1'b0;
    void'($urandom(36));
    straps = 4'($urandom());
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // pins tristated and core held just after release
    expect_outs(11'h003, 11'h787);
    wait_run();
    expect_outs(run_exp, 11'h7ff);
    ahb(1'b0, `STRAPS_OFFSET, {28'h0, straps});
    ahb(1'b0, `STATUS_OFFSET, {24'h0, ~straps[2], ~straps[1], straps[0], 5'b1_0101});
    ahb(1'b0, 12'h010, 32'h0);
    // override register: reset value, then a written value reads back
    ahb(1'b0, `OVERRIDE_OFFSET, `OVERRIDE_RESET_VALUE);
    ahb(1'b1, `OVERRIDE_OFFSET, 32'h0000_0000);
    ahb(1'b0, `OVERRIDE_OFFSET, 32'h0000_0000);
    // later pin activity must not reach the latched defaults
    straps <= ~straps;
    repeat (5) @(posedge hclk);
    expect_outs(run_exp, 11'h7ff);
    // phy-only reset pulses its own reset and leaves the mac running
    ahb(1'b1, `CTRL_OFFSET, 32'h0000_0002);
    expect_outs(11'h080, 11'h181);
    // mac-only reset forces the spi outputs low
    ahb(1'b1, `CTRL_OFFSET, 32'h0000_0004);
    expect_outs(11'h001, 11'h081);
    repeat (200) @(posedge hclk);
    // short glitch is filtered out
    board_reset_source_i.pin_low(120);
    expect_outs(run_exp, 11'h7ff);
    // full-length pin reset reruns the sequence and relatches straps
    board_reset_source_i.pin_low(1250);
    expect_outs(11'h003, 11'h787);
    wait_run();
    expect_outs(run_exp, 11'h7ff);
    // brown-out holds reset until supplies are good again
    board_reset_source_i.supply_dip(30);
    expect_outs(11'h003, 11'h787);
    wait_run();
    expect_outs(run_exp, 11'h7ff);
    // full soft reset reruns the sequence and relatches fresh strap levels
    straps <= 4'($urandom());
    ahb(1'b1, `CTRL_OFFSET, 32'h0000_0001);
    @(posedge hclk);
    expect_outs(11'h003, 11'h787);
    wait_run();
    expect_outs(run_exp, 11'h7ff);
    repeat (4) @(posedge hclk);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
